// ==== common/xpoint_regs.vh ====
// Register offsets, field positions and routing patterns of the switch
`ifndef XPOINT_REGS_VH
`define XPOINT_REGS_VH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define XP_ADDR_CTRL 8'h00
`define XP_ADDR_STAT 8'h04
`define XP_ADDR_FRMS 8'h08

// ****************************************************************
// Control register fields
// ****************************************************************
`define XP_CTRL_COL_LSB 0
`define XP_CTRL_ROW_LSB 4
`define XP_CTRL_RESYNC 8
`define XP_CTRL_RST 8'h00

// ****************************************************************
// Status register fields
// ****************************************************************
`define XP_STAT_MODE 0
`define XP_STAT_SEL_HI 1
`define XP_STAT_SEL_LO 2
`define XP_STAT_COMMIT 3
`define XP_STAT_BITS_LSB 4
`define XP_STAT_ROUTE_LSB 8
`define XP_STAT_LOAD_LSB 16
`define XP_STAT_CFG_LSB 24

// ****************************************************************
// Serial frame layout, sent least significant bit first
// ****************************************************************
`define XP_FRAME_BITS 16
`define XP_FRAME_LAST 4'hF
`define XP_ADDR_W 4
`define XP_COL_FIRST 4'h0
`define XP_COL_LAST 4'h3
`define XP_ROW_FIRST 4'h4
`define XP_ROW_LAST 4'h7
`define XP_ROUTE_LSB 8

// ****************************************************************
// Routing patterns: two-bit source code per output, output 1 lowest
// ****************************************************************
`define XP_ROUTE_DIST1 8'h00
`define XP_ROUTE_DIST2 8'h55
`define XP_ROUTE_REDUN 8'hA0
`define XP_ROUTE_BROAD 8'hE4
`define XP_CFG_RST 8'hE4

// ****************************************************************
// Serial clock limit kept by the controller
// ****************************************************************
`define XP_SCLK_MAX_MHZ 100

`endif

// ==== design/crosspoint_mux.v ====
// Four registered 4:1 selectors fed by synchronised shared inputs
module crosspoint_mux (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Shared inputs, one bit per input port
  input wire [3:0] in_i,
  // Two-bit source code per output, output 1 lowest
  input wire [7:0] route_i,
  // Switched outputs
  output reg [3:0] out_o
);

  reg [3:0] in_meta_q;
  reg [3:0] in_sync_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      in_meta_q <= 4'h0;
      in_sync_q <= 4'h0;
    end else begin
      in_meta_q <= in_i;
      in_sync_q <= in_meta_q;
    end
  end

  // ****************************************************************
  // One selector per output, any input may feed several outputs
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sel
      always @(posedge clk_i) begin
        if (rst_i) begin
          out_o[g] <= 1'b0;
        end else begin
          out_o[g] <= in_sync_q[route_i[2*g+1:2*g]]; // [R1]
        end
      end
    end
  endgenerate

endmodule // crosspoint_mux

// ==== design/crosspoint_switch_control.v ====
// Routing control of a 4x4 cross-point switch with serial and direct ports
//
// How it works
// [R1] Four independent 4:1 selectors; any input may feed any outputs.
// [R2] Mode pin low selects serial port, high selects direct select pins.
// [R3] In serial mode one commit updates all four outputs together.
// [R4] In direct mode routing follows decoded select pins without commit.
// [R5] Mode low, commit low: each serial clock rise shifts data in.
// [R6] Controller keeps serial clock at most 100 MHz, bursts only.
// [R7] Cascade data repeats input with column or row address decremented.
// [R8] Cascade data outputs change on serial clock rising edges.
// [R9] Mode low: cascade clock outputs copy the serial clock.
// [R10] Commit high at serial clock rise copies load into configuration.
// [R11] Commit held high repeats the copy at every serial clock rise.
// [R12] Commit uses last valid frame; routing follows configuration at once.
// [R13] Mode high: serial clock ignored, cascade clocks held low.
// [R14] Select pins ignored in serial mode; select high doubles as data.
// [R15] Direct 00 routes input 1, 01 routes input 2 to all.
// [R16] Direct 10: input 1 to outputs 1,2; input 3 to 3,4.
// [R17] Direct 11: each input to the output of same index.
// [R18] Frame: column, row address, then two-bit codes; valid on match.
// [R19] Registers start at straight routing until the first commit.
//
// Added by the designer: the register offsets and register access over Wishbone.
`include "xpoint_regs.vh"

module crosspoint_switch_control (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Control pins
  input wire mode_i,
  input wire serial_clock_i,
  input wire serial_in_or_select_hi_i,
  input wire select_lo_i,
  input wire commit_i,
  // Cascade outputs
  output reg column_cascade_data_out_o,
  output reg row_cascade_data_out_o,
  output reg column_cascade_clock_out_o,
  output reg row_cascade_clock_out_o,
  output reg buffered_clock_out_o,
  // Data path
  input wire input_port_1_i,
  input wire input_port_2_i,
  input wire input_port_3_i,
  input wire input_port_4_i,
  output wire output_port_1_o,
  output wire output_port_2_o,
  output wire output_port_3_o,
  output wire output_port_4_o
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  reg [4:0] pin_meta_q;
  reg [4:0] pin_sync_q;
  reg sclk_prev_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_q <= 5'h00;
      pin_sync_q <= 5'h00;
      sclk_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= {commit_i, select_lo_i, serial_in_or_select_hi_i,
                     serial_clock_i, mode_i};
      pin_sync_q <= pin_meta_q;
      sclk_prev_q <= pin_sync_q[1];
    end
  end

  wire mode_s = pin_sync_q[0];
  wire sclk_s = pin_sync_q[1];
  wire sdata_s = pin_sync_q[2];
  wire sel_lo_s = pin_sync_q[3];
  wire commit_s = pin_sync_q[4];

  // Internal serial clock edge, seen only in serial mode
  wire sclk_rise = sclk_s & ~sclk_prev_q & ~mode_s; // [R13] [R2]
  wire shift_en = sclk_rise & ~commit_s; // [R5]
  wire commit_en = sclk_rise & commit_s; // [R10] [R11]

  // ****************************************************************
  // Register interface state
  // ****************************************************************
  reg [7:0] ctrl_q;
  reg [7:0] frames_q;
  reg resync_q;

  wire [3:0] own_col = ctrl_q[`XP_CTRL_COL_LSB +: `XP_ADDR_W];
  wire [3:0] own_row = ctrl_q[`XP_CTRL_ROW_LSB +: `XP_ADDR_W];

  // ****************************************************************
  // Frame receiver
  // ****************************************************************
  reg [15:0] shift_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] load_q;
  reg [7:0] cfg_q;
  reg col_borrow_q;
  reg row_borrow_q;

  wire [15:0] shift_d = {sdata_s, shift_q[15:1]}; // [R5] [R14]
  wire frame_done = shift_en && (bit_cnt_q == `XP_FRAME_LAST);
  wire frame_match =
    (shift_d[`XP_COL_LAST:`XP_COL_FIRST] == own_col) &&
    (shift_d[`XP_ROW_LAST:`XP_ROW_FIRST] == own_row); // [R18]

  always @(posedge clk_i) begin
    if (rst_i) begin
      shift_q <= 16'h0000; // [R19]
      bit_cnt_q <= 4'h0;
      load_q <= `XP_CFG_RST; // [R19]
      cfg_q <= `XP_CFG_RST; // [R19]
      frames_q <= 8'h00;
    end else begin
      if (mode_s || resync_q) begin
        bit_cnt_q <= 4'h0;
      end else if (shift_en) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      if (shift_en) begin
        shift_q <= shift_d; // [R5]
      end
      if (frame_done && frame_match) begin
        load_q <= shift_d[15:`XP_ROUTE_LSB]; // [R12] [R18]
        frames_q <= frames_q + 8'h01;
      end
      if (commit_en) begin
        cfg_q <= load_q; // [R10] [R11] [R3]
      end
    end
  end

  // ****************************************************************
  // Cascade outputs with on-the-fly address decrement
  // ****************************************************************
  wire in_col = (bit_cnt_q <= `XP_COL_LAST);
  wire in_row = (bit_cnt_q >= `XP_ROW_FIRST) &&
                (bit_cnt_q <= `XP_ROW_LAST);
  wire col_borrow = (bit_cnt_q == `XP_COL_FIRST) ? 1'b1 : col_borrow_q;
  wire row_borrow = (bit_cnt_q == `XP_ROW_FIRST) ? 1'b1 : row_borrow_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      column_cascade_data_out_o <= 1'b0;
      row_cascade_data_out_o <= 1'b0;
      col_borrow_q <= 1'b0;
      row_borrow_q <= 1'b0;
    end else if (shift_en) begin
      // Serial subtract of one, least significant bit first
      if (in_col) begin
        column_cascade_data_out_o <= sdata_s ^ col_borrow; // [R7] [R8]
        col_borrow_q <= col_borrow & ~sdata_s;
      end else begin
        column_cascade_data_out_o <= sdata_s; // [R7] [R8]
      end
      if (in_row) begin
        row_cascade_data_out_o <= sdata_s ^ row_borrow; // [R7] [R8]
        row_borrow_q <= row_borrow & ~sdata_s;
      end else begin
        row_cascade_data_out_o <= sdata_s; // [R7] [R8]
      end
    end
  end

  // Cascade clocks follow the sampled serial clock, low in direct mode
  always @(posedge clk_i) begin
    if (rst_i) begin
      column_cascade_clock_out_o <= 1'b0;
      row_cascade_clock_out_o <= 1'b0;
      buffered_clock_out_o <= 1'b0;
    end else begin
      column_cascade_clock_out_o <= sclk_s & ~mode_s; // [R9] [R13]
      row_cascade_clock_out_o <= sclk_s & ~mode_s; // [R9] [R13]
      buffered_clock_out_o <= sclk_s & ~mode_s; // [R9] [R13]
    end
  end

  // ****************************************************************
  // Route selection
  // ****************************************************************
  reg [7:0] direct_route;
  reg [7:0] route_q;

  always @* begin
    case ({sdata_s, sel_lo_s})
      2'b00: direct_route = `XP_ROUTE_DIST1; // [R15]
      2'b01: direct_route = `XP_ROUTE_DIST2; // [R15]
      2'b10: direct_route = `XP_ROUTE_REDUN; // [R16]
      2'b11: direct_route = `XP_ROUTE_BROAD; // [R17]
      default: direct_route = `XP_ROUTE_BROAD;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      route_q <= `XP_CFG_RST; // [R19]
    end else if (mode_s) begin
      route_q <= direct_route; // [R4] [R2]
    end else begin
      route_q <= cfg_q; // [R12] [R14]
    end
  end

  crosspoint_mux u_mux (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_i({input_port_4_i, input_port_3_i, input_port_2_i, input_port_1_i}),
    .route_i(route_q),
    .out_o({output_port_4_o, output_port_3_o, output_port_2_o,
            output_port_1_o})
  ); // [R1]

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  wire req = cyc_i & stb_i;
  reg [31:0] rd_data;

  always @* begin
    rd_data = 32'h00000000;
    case (adr_i)
      `XP_ADDR_CTRL: rd_data[7:0] = ctrl_q;
      `XP_ADDR_STAT: begin
        rd_data[`XP_STAT_MODE] = mode_s;
        rd_data[`XP_STAT_SEL_HI] = sdata_s;
        rd_data[`XP_STAT_SEL_LO] = sel_lo_s;
        rd_data[`XP_STAT_COMMIT] = commit_s;
        rd_data[`XP_STAT_BITS_LSB +: 4] = bit_cnt_q;
        rd_data[`XP_STAT_ROUTE_LSB +: 8] = route_q;
        rd_data[`XP_STAT_LOAD_LSB +: 8] = load_q;
        rd_data[`XP_STAT_CFG_LSB +: 8] = cfg_q;
      end
      `XP_ADDR_FRMS: rd_data[7:0] = frames_q;
      default: rd_data = 32'h00000000;
    endcase
  end

  // Answer one cycle after the request; writes land on the ack edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      ctrl_q <= `XP_CTRL_RST;
      resync_q <= 1'b0;
    end else begin
      ack_o <= req & ~ack_o;
      resync_q <= 1'b0;
      if (req & ~ack_o) begin
        dat_o <= rd_data;
      end
      if (req && ack_o && we_i && (adr_i == `XP_ADDR_CTRL)) begin
        if (sel_i[0]) begin
          ctrl_q <= dat_i[7:0];
        end
        if (sel_i[1]) begin
          resync_q <= dat_i[`XP_CTRL_RESYNC];
        end
      end
    end
  end

endmodule // crosspoint_switch_control

// ==== test/crosspoint_switch_control_properties.sv ====
// Pin-level assertions for the cross-point switch control
module xpoint_checker (
  input logic clk_i, rst_i, mode_i, serial_clock_i,
  input logic serial_in_or_select_hi_i, select_lo_i,
  input logic column_cascade_data_out_o, row_cascade_data_out_o,
  input logic column_cascade_clock_out_o, row_cascade_clock_out_o,
  input logic buffered_clock_out_o,
  input logic input_port_1_i, input_port_2_i,
  input logic input_port_3_i, input_port_4_i,
  input logic output_port_1_o, output_port_2_o,
  input logic output_port_3_o, output_port_4_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [3:0] ins = {input_port_4_i, input_port_3_i,
    input_port_2_i, input_port_1_i};
  wire [3:0] outs = {output_port_4_o, output_port_3_o,
    output_port_2_o, output_port_1_o};
  wire [1:0] sel = {serial_in_or_select_hi_i, select_lo_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_dist1;
    (mode_i && sel == 2'b00 && $stable(ins))[*8] |-> outs == {4{ins[0]}};
  endproperty
  a_dist1: assert property (p_dist1) else $error("dist1 wrong");
  property p_dist2;
    (mode_i && sel == 2'b01 && $stable(ins))[*8] |-> outs == {4{ins[1]}};
  endproperty
  a_dist2: assert property (p_dist2) else $error("dist2 wrong");
  property p_redun;
    (mode_i && sel == 2'b10 && $stable(ins))[*8]
      |-> outs == {ins[2], ins[2], ins[0], ins[0]};
  endproperty
  a_redun: assert property (p_redun) else $error("redun wrong");
  property p_broad;
    (mode_i && sel == 2'b11 && $stable(ins))[*8] |-> outs == ins;
  endproperty
  a_broad: assert property (p_broad) else $error("broad wrong");
  property p_clk_low;
    mode_i[*6] |-> !column_cascade_clock_out_o && !row_cascade_clock_out_o;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("clock not low");
  property p_clk_copy;
    (!mode_i)[*6] ##0 $rose(serial_clock_i)
      |-> ##[2:5] (buffered_clock_out_o && column_cascade_clock_out_o);
  endproperty
  a_clk_copy: assert property (p_clk_copy) else $error("no clock");
  property p_clk_pair;
    column_cascade_clock_out_o == row_cascade_clock_out_o;
  endproperty
  a_clk_pair: assert property (p_clk_pair) else $error("clk pair");
  property p_casc_edge;
    $changed(column_cascade_data_out_o) |-> $past(serial_clock_i, 2);
  endproperty
  a_casc_edge: assert property (p_casc_edge) else $error("casc edge");
endmodule // xpoint_checker

bind crosspoint_switch_control xpoint_checker chk (.clk_i, .rst_i,
  .mode_i, .serial_clock_i, .serial_in_or_select_hi_i, .select_lo_i,
  .column_cascade_data_out_o, .row_cascade_data_out_o,
  .column_cascade_clock_out_o, .row_cascade_clock_out_o,
  .buffered_clock_out_o, .input_port_1_i, .input_port_2_i,
  .input_port_3_i, .input_port_4_i, .output_port_1_o,
  .output_port_2_o, .output_port_3_o, .output_port_4_o);

// ==== test/serial_ctrl_model.sv ====
// Serial controller that programs the switch over its serial port
module serial_ctrl_model (
  input logic clk_i,
  output logic sclk_o, sdata_o, commit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    commit_o = 1'b0;
  end
  task automatic half;
    repeat (4) @(posedge clk_i);
  endtask
  // Clock burst of one period, held low afterwards
  task automatic rise;
    sclk_o <= 1'b1;
    half;
    sclk_o <= 1'b0;
    half;
  endtask
  task automatic send(input logic [15:0] f);
    for (int i = 0; i < 16; i++) begin
      sdata_o <= f[i];
      half;
      rise;
    end
    sdata_o <= ~f[15];
  endtask
  task automatic commit(input int n);
    commit_o <= 1'b1;
    half;
    repeat (n) rise;
    commit_o <= 1'b0;
  endtask
endmodule // serial_ctrl_model

// ==== test/tb_crosspoint_switch_control.sv ====
// Self-checking bench for the cross-point switch control
module tb_crosspoint_switch_control;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
    n_mismatch++; $display("mismatch at %0t: got %h want %h", \
    $time, a, b); end end
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mode = 0;
  logic s_hi = 0, s_lo = 0, ack, sclk, sdat, cmt, ccd, rcd;
  logic [7:0] adr = 0, r8;
  logic [31:0] wdat = 0, rdat, q;
  logic [3:0] ins = 0, outs;
  logic [15:0] ccap, rcap, e;
  int n_mismatch = 0, n_checks = 0;
  serial_ctrl_model ctl (.clk_i, .sclk_o(sclk), .sdata_o(sdat),
    .commit_o(cmt));
  crosspoint_switch_control uut (.clk_i, .rst_i, .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .mode_i(mode), .serial_clock_i(sclk),
    .serial_in_or_select_hi_i(mode ? s_hi : sdat), .select_lo_i(s_lo),
    .commit_i(cmt), .column_cascade_data_out_o(ccd),
    .row_cascade_data_out_o(rcd), .column_cascade_clock_out_o(),
    .row_cascade_clock_out_o(), .buffered_clock_out_o(),
    .input_port_1_i(ins[0]), .input_port_2_i(ins[1]),
    .input_port_3_i(ins[2]), .input_port_4_i(ins[3]),
    .output_port_1_o(outs[0]), .output_port_2_o(outs[1]),
    .output_port_3_o(outs[2]), .output_port_4_o(outs[3]));
  initial forever #20 clk_i = ~clk_i;
  // Cascade outputs captured once settled in each serial period
  always @(negedge sclk) begin
    @(negedge clk_i);
    ccap <= {ccd, ccap[15:1]};
    rcap <= {rcd, rcap[15:1]};
  end
  function automatic logic [3:0] route(input logic [7:0] r,
    input logic [3:0] v);
    for (int o = 0; o < 4; o++) route[o] = v[r[2*o +: 2]];
  endfunction
  function automatic logic [7:0] pat(input int s);
    return s == 0 ? 8'h00 : s == 1 ? 8'h55 : s == 2 ? 8'hA0 : 8'hE4;
  endfunction
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic settle;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h3AA9A511));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    ins <= 4'($urandom);
    settle;
    `CHK(outs, ins)
    wb(1'b0, 8'h0C, 32'h0);
    `CHK(q, 32'h0)
    wb(1'b0, 8'h00, 32'h0);
    `CHK(q[7:0], 8'h00)
    for (int r = 0; r < 8; r++) begin
      mode <= 1'b1;
      {s_hi, s_lo} <= 2'(r % 4);
      ins <= 4'($urandom);
      settle;
      `CHK(outs, route(pat(r % 4), ins))
    end
    ctl.send(16'h0000);
    ctl.commit(1);
    settle;
    `CHK(outs, ins)
    // Serial traffic in direct mode must leave every register untouched
    wb(1'b0, 8'h04, 32'h0);
    `CHK(q, 32'hE4E4E407)
    mode <= 1'b0;
    s_lo <= 1'b0;
    r8 = 8'($urandom) | 8'h03;
    settle;
    ctl.send({r8, 8'h00});
    `CHK(outs, ins)
    e = {r8, 8'h0F};
    `CHK(ccap, e)
    e = {r8, 8'hF0};
    `CHK(rcap, e)
    ctl.commit(1);
    settle;
    `CHK(outs, route(r8, ins))
    wb(1'b1, 8'h00, 32'h11);
    wb(1'b0, 8'h00, 32'h0);
    `CHK(q[7:0], 8'h11)
    ctl.send({~r8, 8'h00});
    ctl.commit(2);
    ins <= 4'($urandom);
    settle;
    `CHK(outs, route(r8, ins))
    // Commit edges must not shift: bit count stays on the frame boundary
    wb(1'b0, 8'h04, 32'h0);
    `CHK(q[31:4], {r8, r8, r8, 4'h0})
    wb(1'b0, 8'h08, 32'h0);
    `CHK(q[7:0], 8'h01)
    tally_and_finish;
  end
endmodule // tb_crosspoint_switch_control
